// *** src/ipl_defines.svh ***
// constants for the input polarity and latch configuration block
// assumes inclusion by bare name from design files
`ifndef IPL_DEFINES_SVH
`define IPL_DEFINES_SVH

// register byte addresses, one 16-bit word per 32-bit slot
`define IPL_ADDR_POL0 8'h00
`define IPL_ADDR_LAT0 8'h04
`define IPL_ADDR_POL1 8'h08
`define IPL_ADDR_LAT1 8'h0c
`define IPL_ADDR_POL2 8'h10
`define IPL_ADDR_LAT2 8'h14
`define IPL_ADDR_STAT 8'h18
`define IPL_ADDR_ACT 8'h1c

// reset value of every setting word
`define IPL_WORD_RST 16'h0000

// field positions inside the setting words
`define IPL_POL_BIT 0
`define IPL_FUNC_BIT 0
`define IPL_EDGE_BIT 4

`endif

// *** src/ipl_pkg.sv ***
// types shared by the input polarity and latch configuration block
// assumes ipl_defines.svh is compiled alongside
package ipl_pkg;

  // configuration of one pin as applied to its behaviour
  typedef struct packed {
    logic invert;
    logic latch_en;
    logic falling;
  } ipl_cfg_s;

  // conditioned output of one pin
  typedef struct packed {
    logic level;
    logic latch_pulse;
  } ipl_pin_out_s;

endpackage

// *** src/ipl_pin.sv ***
// per-pin conditioning: polarity, function and latch edge
// assumes pin inputs already synchronous to clk_sys
`timescale 1ns/1ps
`default_nettype none

module ipl_pin (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire ipl_pkg::ipl_cfg_s cfg,
  input wire logic pin,
  output ipl_pkg::ipl_pin_out_s pin_out
);

  logic prev_reg;
  logic level_reg;
  logic pulse_reg;
  wire logic level_w;
  wire logic rise_w;
  wire logic fall_w;
  wire logic edge_w;

  // polarity applied before edge detection so edges follow the inverted level
  assign level_w = pin ^ cfg.invert;
  assign rise_w = level_w & ~prev_reg;
  assign fall_w = ~level_w & prev_reg;
  assign edge_w = cfg.falling ? fall_w : rise_w;

  // history, level output and latch pulse
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prev_reg <= 1'b0;
      level_reg <= 1'b0;
      pulse_reg <= 1'b0;
    end else begin
      prev_reg <= level_w;
      level_reg <= cfg.latch_en ? 1'b0 : level_w;
      pulse_reg <= cfg.latch_en & edge_w;
    end
  end

  assign pin_out.level = level_reg;
  assign pin_out.latch_pulse = pulse_reg;

endmodule

`default_nettype wire

// *** src/ipl_regs.sv ***
// setting word storage for three pins, polarity and latch words each
// assumes one-cycle write strobes from a plain register port
`timescale 1ns/1ps
`default_nettype none
`include "ipl_defines.svh"

module ipl_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  output logic [15:0] pol_word [3],
  output logic [15:0] lat_word [3]
);

  logic warm_reg;

  // set at the first release; later resets keep the words
  // limitation: needs warm_reg to come up low at power-on
  always_ff @(posedge clk_sys) begin
    if (rst_n) begin
      warm_reg <= 1'b1;
    end
  end

  // separate storage per pin, nothing shared between them
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_word
      wire logic hit_pol;
      wire logic hit_lat;
      assign hit_pol = wr_en & (addr == 8'(`IPL_ADDR_POL0 + 8 * i));
      assign hit_lat = wr_en & (addr == 8'(`IPL_ADDR_LAT0 + 8 * i));
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          // words survive a warm reset so they can be applied at release
          if (warm_reg) begin
            pol_word[i] <= pol_word[i];
            lat_word[i] <= lat_word[i];
          end else begin
            pol_word[i] <= `IPL_WORD_RST;
            lat_word[i] <= `IPL_WORD_RST;
          end
        end else begin
          if (hit_pol) begin
            pol_word[i] <= wdata;
          end
          if (hit_lat) begin
            lat_word[i] <= wdata;
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// *** src/ipl_top.sv ***
// input polarity and timing latch configuration for three input pins
// assumes synchronous pins and a plain register port on clk_sys
//
// Operation
// - polarity field 0 passes pin level, 1 inverts it; default 0
// - function field 0 plain level input, 1 timing latch trigger
// - latch on rising edge when edge field 0, falling when 1
// - edge in second hex digit, function in lowest digit
// - each pin keeps its own pair of setting words
`timescale 1ns/1ps
`default_nettype none
`include "ipl_defines.svh"

module ipl_top (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic input_pin_ten,
  input wire logic input_pin_eleven,
  input wire logic input_pin_twelve,
  output logic [2:0] pin_level,
  output logic [2:0] latch_pulse
);

  logic [15:0] pol_word [3];
  logic [15:0] lat_word [3];
  ipl_pkg::ipl_cfg_s act_reg [3];
  logic load_reg;
  logic [31:0] rdata_reg;
  wire logic [2:0] pins;
  wire logic [31:0] rdata_next;
  ipl_pkg::ipl_pin_out_s pin_out [3];

  assign pins = {input_pin_twelve, input_pin_eleven, input_pin_ten};

  // word storage
  ipl_regs u_regs (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .addr(addr),
    .wdata(wdata),
    .wr_en(wr_en),
    .pol_word(pol_word),
    .lat_word(lat_word)
  );

  // field decode used at load only; readback returns the raw words and act_reg
  function automatic ipl_pkg::ipl_cfg_s decode(input logic [15:0] pw,
                                              input logic [15:0] lw);
    ipl_pkg::ipl_cfg_s c;
    c.invert = pw[`IPL_POL_BIT];
    c.latch_en = lw[`IPL_FUNC_BIT];
    c.falling = lw[`IPL_EDGE_BIT];
    return c;
  endfunction

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      load_reg <= 1'b1;
    end else begin
      load_reg <= 1'b0;
    end
  end

  // per-pin active configuration and conditioning
  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_pin
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          act_reg[i] <= '0;
        end else if (load_reg) begin
          act_reg[i] <= decode(pol_word[i], lat_word[i]);
        end
      end
      ipl_pin u_pin (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .cfg(act_reg[i]),
        .pin(pins[i]),
        .pin_out(pin_out[i])
      );
      assign pin_level[i] = pin_out[i].level;
      assign latch_pulse[i] = pin_out[i].latch_pulse;
    end
  endgenerate

  // readback mux; unmapped addresses read zero
  assign rdata_next =
    (addr == `IPL_ADDR_POL0) ? {16'h0000, pol_word[0]} :
    (addr == `IPL_ADDR_LAT0) ? {16'h0000, lat_word[0]} :
    (addr == `IPL_ADDR_POL1) ? {16'h0000, pol_word[1]} :
    (addr == `IPL_ADDR_LAT1) ? {16'h0000, lat_word[1]} :
    (addr == `IPL_ADDR_POL2) ? {16'h0000, pol_word[2]} :
    (addr == `IPL_ADDR_LAT2) ? {16'h0000, lat_word[2]} :
    (addr == `IPL_ADDR_STAT) ? {29'h0, pins} :
    (addr == `IPL_ADDR_ACT) ? {23'h0, act_reg[2], act_reg[1], act_reg[0]} :
    32'h0000_0000;

  // read data valid the cycle after the strobe only
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rd_en ? rdata_next : 32'h0000_0000;
    end
  end

  assign rdata = rdata_reg;

endmodule

`default_nettype wire

// *** tb/ipl_chk.sv ***
// checker: port relations of ipl_top
// assumes a bind from the bench top file
`timescale 1ns/1ps
`default_nettype none
module ipl_chk (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic [31:0] rdata,
  input wire logic input_pin_ten,
  input wire logic input_pin_eleven,
  input wire logic input_pin_twelve,
  input wire logic [2:0] pin_level,
  input wire logic [2:0] latch_pulse
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // read data only in the cycle after a read strobe
  property p_idle; !$past(rd_en) |-> rdata == 32'h0; endproperty
  a_idle: assert property (p_idle) else $error("rdata not idle");
  property p_up; $past(rd_en) |-> rdata[31:16] == 16'h0; endproperty
  a_up: assert property (p_up) else $error("rdata upper set");
  property p_un; $past(rd_en) && $past(addr) > 8'h1c |-> rdata == 32'h0;
  endproperty
  a_un: assert property (p_un) else $error("unmapped read");
  property p_st; $past(rd_en) && $past(addr) == 8'h18
    |-> rdata[0] == $past(input_pin_ten); endproperty
  a_st: assert property (p_st) else $error("raw pin read");
  // outputs quiet on the first edge out of reset
  property p_rst; $rose(rst_n) |-> pin_level == 3'h0 && latch_pulse == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
  // guard of four edges: config loads just after release
  property p_lvl; $past(rst_n, 4) && $changed(pin_level[0])
    |-> $past(input_pin_ten) != $past(input_pin_ten, 2); endproperty
  a_lvl: assert property (p_lvl) else $error("level moved alone");
  property p_pls; $past(rst_n, 4) && latch_pulse[1]
    |-> $past(input_pin_eleven) != $past(input_pin_eleven, 2); endproperty
  a_pls: assert property (p_pls) else $error("pulse without edge");
  property p_one; latch_pulse[2] |=> !latch_pulse[2]; endproperty
  a_one: assert property (p_one) else $error("pulse too long");
  property p_ex; latch_pulse[1] |-> !pin_level[1]; endproperty
  a_ex: assert property (p_ex) else $error("level in latch mode");
endmodule
`default_nettype wire

// *** tb/ipl_sw.sv ***
// switch model: three contacts following a commanded pattern
// assumes the bench changes cmd just after a rising edge
`timescale 1ns/1ps
`default_nettype none
module ipl_sw (
  input wire logic clk_sys,
  input wire logic [2:0] cmd,
  output logic [2:0] pins = 3'h0
);
  // contacts settle one clock late, never mid-cycle
  always @(posedge clk_sys) begin
    pins <= cmd;
  end
endmodule
`default_nettype wire

// *** tb/test_ipl_top.sv ***
// bench for ipl_top: word table, reset, pin sequences
// assumes ipl_chk and ipl_sw are compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_ipl_top;
  logic clk_sys = 0, rst_n = 0, wr_en = 0, rd_en = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic [2:0] cmd = 3'h0, pins, lvl, pls;
  logic [31:0] rdata;
  int errors = 0, checks_done = 0;
  // address, write data, readback; manufacturer digits kept zero
  logic [39:0] rows [9] = '{40'h00_0001_0001, 40'h04_0000_0000,
    40'h08_0000_0000, 40'h0c_0001_0001, 40'h10_0001_0001,
    40'h14_0011_0011, 40'h18_ffff_0000, 40'h1c_ffff_0000,
    40'h20_1234_0000};
  always #2.5 clk_sys = ~clk_sys;
  ipl_sw sw (.clk_sys(clk_sys), .cmd(cmd), .pins(pins));
  ipl_top uut (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr),
    .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
    .input_pin_ten(pins[0]), .input_pin_eleven(pins[1]),
    .input_pin_twelve(pins[2]), .pin_level(lvl), .latch_pulse(pls));
  // shared compare, counts every check
  task automatic chk(input string n, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rst();
    @(posedge clk_sys);
    rst_n <= 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask
  // data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 0;
    #1 chk("rdata", e, rdata);
  endtask
  // pins lag cmd one edge, outputs one more
  task automatic step(input logic [2:0] p, l, q);
    @(posedge clk_sys);
    cmd <= p;
    repeat (2) @(posedge clk_sys);
    #1 chk("pin_level", {29'h0, l}, {29'h0, lvl});
    chk("latch_pulse", {29'h0, q}, {29'h0, pls});
  endtask
  task automatic end_of_test();
    $display("errors %0d checks_done %0d", errors, checks_done);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // table first, then the awkward cases across a second reset
  initial begin
    rst();
    foreach (rows[i]) begin
      rd(rows[i][39:32], 32'h0);
      wr(rows[i][39:32], rows[i][31:16]);
      rd(rows[i][39:32], {16'h0, rows[i][15:0]});
    end
    step(3'h7, 3'h7, 3'h0);
    step(3'h0, 3'h0, 3'h0);
    rst();
    rd(8'h1c, 32'h1d4);
    step(3'h2, 3'h1, 3'h2);
    step(3'h2, 3'h1, 3'h0);
    step(3'h5, 3'h0, 3'h4);
    step(3'h0, 3'h1, 3'h0);
    end_of_test();
  end
endmodule
bind ipl_top ipl_chk chk (.*);
`default_nettype wire
